// *** shared/cbes_pkg.sv ***
// Package for the card bus error status block: register map, field
// positions, reset values and timing counts.
// Assumes a 25 MHz system clock and a 32-bit APB register bus.
package cbes_pkg;

  // Register byte offsets
  localparam logic [7:0] CBES_OFS_ERR_FLAGS = 8'h00;  // bus_error_flags, W1C
  localparam logic [7:0] CBES_OFS_CTRL      = 8'h04;  // power and mode control
  localparam logic [7:0] CBES_OFS_IRQ_STAT  = 8'h08;  // sticky events, read clears
  localparam logic [7:0] CBES_OFS_IRQ_MASK  = 8'h0c;  // 1 lets an event through
  localparam logic [7:0] CBES_OFS_STATE     = 8'h10;  // live power state

  // Error flag positions, shared by flags, irq status and irq mask
  localparam int CBES_BIT_CUR_LIMIT = 7;
  localparam int CBES_BIT_DAT_END   = 6;
  localparam int CBES_BIT_DAT_CRC   = 5;
  localparam int CBES_BIT_DAT_TMO   = 4;
  localparam int CBES_BIT_CMD_IDX   = 3;
  localparam int CBES_BIT_CMD_END   = 2;
  localparam int CBES_FLAG_W        = 16;
  localparam logic [15:0] CBES_FLAG_IMPL = 16'h00fc;  // Bits 7..2 live here

  // Control register fields
  localparam int CBES_CTRL_PWR_REQ = 0;
  localparam int CBES_CTRL_LEGACY  = 1;
  localparam logic [1:0] CBES_CTRL_RESET = 2'h2;      // Power off, legacy mode

  // State register fields
  localparam int CBES_STATE_PWR_ON  = 0;
  localparam int CBES_STATE_PWR_CUT = 1;

  // Reset values
  localparam logic [15:0] CBES_FLAGS_RESET = 16'h0000;
  localparam logic [15:0] CBES_MASK_RESET  = 16'h0000;

  // Good write CRC status token
  localparam logic [2:0] CBES_WR_CRC_OK = 3'h2;

  // Over-current sampling time, rounded up to whole clock cycles
  localparam int CBES_CLK_PERIOD_PS = 40000;
  localparam int CBES_OC_SAMPLE_NS  = 1000;
  localparam int CBES_OC_SAMPLE_CYC =
    (CBES_OC_SAMPLE_NS * 1000 + CBES_CLK_PERIOD_PS - 1) / CBES_CLK_PERIOD_PS;

endpackage

// *** hdl/cbes_sync.sv ***
// Three-stage synchroniser for one pin level.
// Assumes an asynchronous input; output changes once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module cbes_sync (
  input  wire logic CLK_SYS,
  input  wire logic RESET,
  input  wire logic PIN_IN,
  output var  logic LEVEL_OUT
);
  logic [2:0] stage_q;
  logic       level_q;
  wire        agree = (stage_q[1] == stage_q[2]);

  // Shift chain; first stage feeds only the second
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      stage_q <= 3'h0;
    end else begin
      stage_q <= {stage_q[1:0], PIN_IN};
    end
  end

  // Accept a change only when the last two stages match
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      level_q <= 1'b0;
    end else if (agree) begin
      level_q <= stage_q[2];
    end
  end

  assign LEVEL_OUT = level_q;
endmodule // cbes_sync
`default_nettype wire

// *** hdl/cbes_oc_filter.sv ***
// Over-current qualifier: a level must hold for SAMPLE_CYC cycles.
// Assumes a synchronised input on the system clock.
`timescale 1ns/1ps
`default_nettype none
module cbes_oc_filter #(
  parameter int SAMPLE_CYC = 25
) (
  input  wire logic CLK_SYS,
  input  wire logic RESET,
  input  wire logic OC_LEVEL,
  output var  logic OC_TRIP
);
  localparam int CW = $clog2(SAMPLE_CYC + 1);
  localparam logic [CW-1:0] CNT_MAX = CW'(SAMPLE_CYC);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  wire           full = (cnt_q == CNT_MAX);

  // Count up while high, restart on any low sample
  assign cnt_d = !OC_LEVEL ? '0 : (full ? cnt_q : cnt_q + CW'(1));

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign OC_TRIP = full;
endmodule // cbes_oc_filter
`default_nettype wire

// *** hdl/cbes_top.sv ***
// Card bus error status bank: error bits 7..2, power cut on current limit,
// interrupt status and mask, all behind an APB slave.
// Assumes card bus event pulses come from logic on CLK_SYS, one cycle each,
// and OVER_CURRENT comes straight from a pin.
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - With power requested and current limiting built in, an over-current cuts card power and sets bit 7.
// - Bit 7 reads 1 while power is withheld after a fault and 0 while power flows without error; the code keeps it 1 until a 1 is written with power_req low.
// - Without current limiting, bit 7 is always zero.
// - A zero sampled at a data end-bit position, read data or CRC status token, sets bit 6.
// - A bad read data CRC or a write CRC status token other than 010 sets bit 5.
// - Any of the four busy, status or read data timeouts sets bit 4.
// - A command index error in a response sets bit 3.
// - A zero response end bit sets bit 2.
// - Bits 6 to 2 are only checked in legacy card bus mode.
module cbes_top
  import cbes_pkg::*;
#(
  parameter bit CURRENT_LIMIT_EN = 1'b1,
  parameter int OC_SAMPLE_CYC    = CBES_OC_SAMPLE_CYC
) (
  input  wire logic        CLK_SYS,
  input  wire logic        RESET,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  input  wire logic [3:0]  PSTRB,
  output var  logic [31:0] PRDATA,
  output var  logic        PREADY,
  output var  logic        PSLVERR,
  input  wire logic        OVER_CURRENT,
  input  wire logic        DAT_END_BIT_ZERO,
  input  wire logic        DAT_RD_CRC_BAD,
  input  wire logic        WR_CRC_STATUS_VALID,
  input  wire logic [2:0]  WR_CRC_STATUS,
  input  wire logic        BUSY_TMO_RESP,
  input  wire logic        BUSY_TMO_WR,
  input  wire logic        WR_CRC_STATUS_TMO,
  input  wire logic        RD_DATA_TMO,
  input  wire logic        CMD_INDEX_BAD,
  input  wire logic        CMD_END_BIT_ZERO,
  output var  logic        CARD_POWER_EN,
  output var  logic        IRQ
);

  // Register state
  logic [15:0] flags_q;
  logic [15:0] flags_d;
  logic [15:0] irq_stat_q;
  logic [15:0] irq_stat_d;
  logic [15:0] irq_mask_q;
  logic [15:0] irq_mask_d;
  logic [1:0]  ctrl_q;
  logic [1:0]  ctrl_d;
  logic        power_cut_q;
  logic        power_cut_d;
  logic        power_en_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [15:0] rd_clr_q;
  logic [15:0] rd_clr_d;

  // Over-current path
  logic oc_level;
  logic oc_trip;

  cbes_sync u_oc_sync (
    .CLK_SYS   (CLK_SYS),
    .RESET     (RESET),
    .PIN_IN    (OVER_CURRENT),
    .LEVEL_OUT (oc_level)
  );

  cbes_oc_filter #(
    .SAMPLE_CYC (OC_SAMPLE_CYC)
  ) u_oc_filter (
    .CLK_SYS  (CLK_SYS),
    .RESET    (RESET),
    .OC_LEVEL (oc_level),
    .OC_TRIP  (oc_trip)
  );

  // APB decode
  wire setup_ph  = PSEL & ~PENABLE;
  wire access_ph = PSEL & PENABLE;
  wire hit_flags = (PADDR == CBES_OFS_ERR_FLAGS);
  wire hit_ctrl  = (PADDR == CBES_OFS_CTRL);
  wire hit_istat = (PADDR == CBES_OFS_IRQ_STAT);
  wire hit_imask = (PADDR == CBES_OFS_IRQ_MASK);
  wire hit_state = (PADDR == CBES_OFS_STATE);
  wire mapped    = hit_flags | hit_ctrl | hit_istat | hit_imask | hit_state;
  wire wr_acc    = access_ph & PWRITE & mapped;
  wire rd_acc    = access_ph & ~PWRITE & mapped;

  // Byte lanes expanded to a 16-bit write mask
  wire [15:0] lane_mask = {{8{PSTRB[1]}}, {8{PSTRB[0]}}};
  wire [15:0] wdata_lo  = PWDATA[15:0] & lane_mask;

  // Mode and power request
  wire legacy_mode = ctrl_q[CBES_CTRL_LEGACY];
  wire power_req   = ctrl_q[CBES_CTRL_PWR_REQ];

  wire wr_tok_bad = WR_CRC_STATUS_VALID & (WR_CRC_STATUS != CBES_WR_CRC_OK);

  wire dat_tmo = BUSY_TMO_RESP | BUSY_TMO_WR | WR_CRC_STATUS_TMO | RD_DATA_TMO;

  // trip only while power is requested and the function exists
  wire oc_cut = CURRENT_LIMIT_EN & power_req & oc_trip;

  // Event vector in flag layout
  logic [15:0] evt_raw;
  logic [15:0] evt;

  always_comb begin
    evt_raw = 16'h0000;
    evt_raw[CBES_BIT_CUR_LIMIT] = power_cut_q;
    evt_raw[CBES_BIT_DAT_END] = DAT_END_BIT_ZERO;
    evt_raw[CBES_BIT_DAT_CRC] = DAT_RD_CRC_BAD | wr_tok_bad;
    evt_raw[CBES_BIT_DAT_TMO] = dat_tmo;
    evt_raw[CBES_BIT_CMD_IDX] = CMD_INDEX_BAD;
    evt_raw[CBES_BIT_CMD_END] = CMD_END_BIT_ZERO;
  end

  // legacy-only checks; bit 7 gone without current limiting
  localparam logic [15:0] LEGACY_BITS = CBES_FLAG_IMPL & 16'h007c;
  localparam logic [15:0] CL_BIT      = CURRENT_LIMIT_EN ? 16'h0080 : 16'h0000;
  assign evt = evt_raw & ((legacy_mode ? LEGACY_BITS : 16'h0000) | CL_BIT);

  wire [15:0] w1c = (wr_acc & hit_flags) ? wdata_lo : 16'h0000;
  assign flags_d = ((flags_q & ~w1c) | evt) & CBES_FLAG_IMPL & ~(~CL_BIT & 16'h0080);

  // Interrupt status: read clears only what that read returned
  wire [15:0] rd_clr = (rd_acc & hit_istat) ? rd_clr_q : 16'h0000;
  assign irq_stat_d = ((irq_stat_q & ~rd_clr) | evt) & CBES_FLAG_IMPL;

  // Mask keeps only implemented bits
  assign irq_mask_d = (wr_acc & hit_imask) ?
                      ((irq_mask_q & ~lane_mask) | (wdata_lo & CBES_FLAG_IMPL)) :
                      irq_mask_q;

  // Control writes, low byte only carries fields
  assign ctrl_d = (wr_acc & hit_ctrl & PSTRB[0]) ? PWDATA[1:0] : ctrl_q;

  // power stays cut until software drops the request
  assign power_cut_d = oc_cut | (power_cut_q & power_req);

  // Read mux, captured in the setup phase so PRDATA comes from a flop
  always_comb begin
    rdata_d  = 32'h0000_0000;
    rd_clr_d = 16'h0000;
    if (hit_flags) begin
      rdata_d = {16'h0000, flags_q};
    end else if (hit_ctrl) begin
      rdata_d = {30'h0, ctrl_q};
    end else if (hit_istat) begin
      rdata_d  = {16'h0000, irq_stat_q};
      rd_clr_d = irq_stat_q;
    end else if (hit_imask) begin
      rdata_d = {16'h0000, irq_mask_q};
    end else if (hit_state) begin
      rdata_d = {30'h0, power_cut_q, power_en_q};
    end
  end

  // Register update
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      flags_q     <= CBES_FLAGS_RESET;
      irq_stat_q  <= CBES_FLAGS_RESET;
      irq_mask_q  <= CBES_MASK_RESET;
      ctrl_q      <= CBES_CTRL_RESET;
      power_cut_q <= 1'b0;
      power_en_q  <= 1'b0;
    end else begin
      flags_q     <= flags_d;
      irq_stat_q  <= irq_stat_d;
      irq_mask_q  <= irq_mask_d;
      ctrl_q      <= ctrl_d;
      power_cut_q <= power_cut_d;
      power_en_q  <= power_req & ~power_cut_d;
    end
  end

  // Read data capture at the setup edge
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      rdata_q  <= 32'h0000_0000;
      rd_clr_q <= 16'h0000;
    end else if (setup_ph & ~PWRITE) begin
      rdata_q  <= rdata_d;
      rd_clr_q <= rd_clr_d;
    end
  end

  // Zero wait states; unmapped addresses answer with an error
  assign PREADY  = 1'b1;
  assign PSLVERR = access_ph & ~mapped;
  assign PRDATA  = rdata_q;

  assign CARD_POWER_EN = power_en_q;

  // Level interrupt from unmasked sticky bits
  assign IRQ = |(irq_stat_q & irq_mask_q);

endmodule // cbes_top
`default_nettype wire

// *** verif/cbes_card_model.sv ***
// Card side model: turns a numbered fault request into one-cycle pulses.
// Assumes the bench asks for at most one fault per cycle.
`timescale 1ns/1ps
`default_nettype none
module cbes_card_model (
  input  wire logic       clk_sys,
  input  wire logic       fire,
  input  wire logic [3:0] kind,
  input  wire logic [2:0] tok,
  output var  logic [8:0] ev_q,
  output var  logic [2:0] tok_q
);
  // One pulse per request; token inverts when not valid so stale values show
  always_ff @(posedge clk_sys) begin
    ev_q <= 9'h000;
    tok_q <= fire ? tok : ~tok_q;
    if (fire) ev_q[kind] <= 1'b1;
  end
endmodule // cbes_card_model
`default_nettype wire

// *** verif/cbes_top_chk.sv ***
// Checker: APB answers, power cut and interrupt release at the top ports.
// Assumes it is bound into every instance of the top module.
`timescale 1ns/1ps
`default_nettype none
module cbes_top_chk #(
  parameter bit CURRENT_LIMIT_EN = 1'b1,
  parameter int OC_SAMPLE_CYC    = 25
) (
  input wire logic        CLK_SYS,
  input wire logic        RESET,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        OVER_CURRENT,
  input wire logic        CARD_POWER_EN,
  input wire logic        IRQ
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  // Access decode
  wire acc = PSEL && PENABLE;
  wire hit = PADDR inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
  wire w4 = acc && PWRITE && PADDR == 8'h04;
  wire w4on = w4 && PWDATA[0];
  wire iacc = PSEL && (PADDR == 8'h08 || PADDR == 8'h0c);
  // Over-current cycles with power on; saturates rather than wrap
  logic [7:0] oc_q;
  always_ff @(posedge CLK_SYS) begin
    if (RESET || !OVER_CURRENT || !CARD_POWER_EN) oc_q <= 8'h00;
    else if (oc_q != 8'hff) oc_q <= oc_q + 8'h01;
  end
  property p_rdy; PREADY; endproperty
  a_rdy: assert property (p_rdy) else $error("pready low");
  property p_err; acc && !hit |-> PSLVERR && (PWRITE || PRDATA == 32'h0); endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
  property p_ok; acc && hit |-> !PSLVERR; endproperty
  a_ok: assert property (p_ok) else $error("mapped access refused");
  property p_setup; !acc |-> !PSLVERR; endproperty
  a_setup: assert property (p_setup) else $error("pslverr outside access");
  property p_hi; PRDATA[31:16] == 16'h0000; endproperty
  a_hi: assert property (p_hi) else $error("upper read bits set");
  property p_oc; CURRENT_LIMIT_EN && oc_q >= OC_SAMPLE_CYC + 8 |-> !CARD_POWER_EN; endproperty
  a_oc: assert property (p_oc) else $error("power not cut");
  property p_filt; $fell(CARD_POWER_EN) |-> $past(w4) || $past(w4, 2) || oc_q >= OC_SAMPLE_CYC;
  endproperty
  a_filt: assert property (p_filt) else $error("power cut too early");
  property p_pwr; $rose(CARD_POWER_EN) |-> $past(w4on) || $past(w4on, 2); endproperty
  a_pwr: assert property (p_pwr) else $error("power without request");
  property p_irq; $fell(IRQ) |-> $past(iacc) || $past(iacc, 2) || $past(iacc, 3); endproperty
  a_irq: assert property (p_irq) else $error("irq dropped by itself");
  c_cut: cover property ($fell(CARD_POWER_EN));
  c_irq: cover property ($rose(IRQ));
  c_err: cover property (acc && !hit);
endmodule // cbes_top_chk
bind cbes_top cbes_top_chk #(.CURRENT_LIMIT_EN(CURRENT_LIMIT_EN), .OC_SAMPLE_CYC(OC_SAMPLE_CYC))
  u_chk (.CLK_SYS(CLK_SYS), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .OVER_CURRENT(OVER_CURRENT), .CARD_POWER_EN(CARD_POWER_EN), .IRQ(IRQ));
`default_nettype wire

// *** verif/test_card_bus_error_status.sv ***
// Bench: APB master, card fault pulses and over-current against the bank.
// Assumes the card model beside the block and a short filter count.
`timescale 1ns/1ps
`default_nettype none
module test_card_bus_error_status
  import cbes_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, oc = 1'b0, fire = 1'b0;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0, rd, e, seed = 32'h7ae5;
  logic [3:0] k = 4'h0, kv;
  logic [2:0] t = 3'h0, tv;
  logic err;
  logic [31:0] rd_ncl;
  localparam int OCN = 2;
  wire [31:0] prd, prd_ncl;
  wire prdy, pse, pwren, irq, pwren_ncl;
  wire [8:0] ev;
  wire [2:0] tokw;
  int failures = 0, n_checks = 0, i;
  initial forever #20 clk = ~clk;
  // Short filter count keeps the over-current case brief
  cbes_top #(.OC_SAMPLE_CYC(OCN)) uut (.CLK_SYS(clk), .RESET(rst), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PSTRB(4'hf), .PRDATA(prd), .PREADY(prdy),
    .PSLVERR(pse), .OVER_CURRENT(oc), .DAT_END_BIT_ZERO(ev[0]), .DAT_RD_CRC_BAD(ev[1]),
    .WR_CRC_STATUS_VALID(ev[2]), .WR_CRC_STATUS(tokw), .BUSY_TMO_RESP(ev[3]),
    .BUSY_TMO_WR(ev[4]), .WR_CRC_STATUS_TMO(ev[5]), .RD_DATA_TMO(ev[6]),
    .CMD_INDEX_BAD(ev[7]), .CMD_END_BIT_ZERO(ev[8]), .CARD_POWER_EN(pwren), .IRQ(irq));
  cbes_card_model u_card (.clk_sys(clk), .fire(fire), .kind(k), .tok(t), .ev_q(ev), .tok_q(tokw));
  // Same stimulus into a build without current limiting
  cbes_top #(.CURRENT_LIMIT_EN(1'b0), .OC_SAMPLE_CYC(OCN)) uut_ncl (.CLK_SYS(clk), .RESET(rst),
    .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PSTRB(4'hf),
    .PRDATA(prd_ncl), .PREADY(), .PSLVERR(), .OVER_CURRENT(oc), .DAT_END_BIT_ZERO(ev[0]),
    .DAT_RD_CRC_BAD(ev[1]), .WR_CRC_STATUS_VALID(ev[2]), .WR_CRC_STATUS(tokw),
    .BUSY_TMO_RESP(ev[3]), .BUSY_TMO_WR(ev[4]), .WR_CRC_STATUS_TMO(ev[5]), .RD_DATA_TMO(ev[6]),
    .CMD_INDEX_BAD(ev[7]), .CMD_END_BIT_ZERO(ev[8]), .CARD_POWER_EN(pwren_ncl), .IRQ());
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // Flag bit expected for each fault source
  function automatic logic [31:0] fexp(input logic [3:0] kk, input logic [2:0] tt);
    case (kk)
      4'h0: return 32'h40;
      4'h1: return 32'h20;
      4'h2: return (tt == 3'h2) ? 32'h0 : 32'h20;
      4'h7: return 32'h08;
      4'h8: return 32'h04;
      default: return 32'h10;
    endcase
  endfunction
  task automatic conclude();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer; waits for pready, bounded
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int j;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (j = 0; j < 20; j++) begin
      @(posedge clk);
      if (prdy === 1'b1) break;
    end
    if (j < 20) begin
      rd = prd;
      rd_ncl = prd_ncl;
      err = pse;
      psel <= 1'b0;
      pen <= 1'b0;
    end else begin
      // Timeout counts as a mismatch and ends the run
      failures++;
      conclude();
    end
  endtask
  task automatic hit(input logic [3:0] kk, input logic [2:0] tt);
    @(posedge clk);
    k <= kk;
    t <= tt;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 5; a++) begin
      apb(1'b0, 8'(a * 4), 32'h0);
      chk(rd, (a == 1) ? 32'h2 : 32'h0);
    end
    apb(1'b0, 8'h14, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, 8'h10, 32'h3);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    // Every source once, a good token, then random sources
    apb(1'b1, 8'h0c, 32'hfc);
    for (int n = 0; n < 24; n++) begin
      seed = xs(seed);
      kv = (n < 9) ? 4'(n) : ((n == 9) ? 4'h2 : 4'(seed[7:0] % 9));
      tv = (n == 9) ? 3'h2 : ((n < 9) ? 3'h7 : seed[10:8]);
      hit(kv, tv);
      e = fexp(kv, tv);
      chk({31'h0, irq}, {31'h0, e != 32'h0});
      apb(1'b1, 8'h00, ~e);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, e);
      apb(1'b0, 8'h08, 32'h0);
      chk(rd, e);
      // IRQ drops only once the clearing edge has settled
      @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, 8'h00, e);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h0);
    end
    // Legacy mode off: data and command faults ignored
    apb(1'b1, 8'h04, 32'h0);
    for (int j = 0; j < 9; j++) hit(4'(j), 3'h0);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // Over-current with power on
    apb(1'b1, 8'h04, 32'h3);
    repeat (2) @(posedge clk);
    chk({31'h0, pwren}, 32'h1);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    oc <= 1'b1;
    for (i = 0; i < 50 && pwren !== 1'b0; i++) @(posedge clk);
    // Sync stages, agreement, OCN samples, then the cut edge
    chk(32'(i >= OCN + 5 && i <= OCN + 7), 32'h1);
    apb(1'b1, 8'h00, 32'h80);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h80);
    chk(rd_ncl, 32'h0);
    chk({31'h0, pwren_ncl}, 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h2);
    chk({31'h0, irq}, 32'h1);
    oc <= 1'b0;
    apb(1'b1, 8'h04, 32'h2);
    apb(1'b1, 8'h00, 32'h80);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h80);
    conclude();
  end
endmodule // test_card_bus_error_status
`default_nettype wire
